// >>> design/imbe_engine.sv
`timescale 1ns/1ns
`default_nettype none
`include "imbe_params.svh"
module imbe_engine #(
  parameter int RW = `IMBE_RELOAD_W,
  parameter int WRITE_COLLISION_FLAG_WIN = `IMBE_WRITE_COLLISION_FLAG_WIN_CYC
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic buf_wr_i,
  input wire logic [7:0] buf_wdata_i,
  input wire logic buf_rd_i,
  input wire logic receive_enable_set_i,
  input wire logic ack_sequence_set_i,
  input wire logic ack_data_bit_i,
  input wire logic write_collision_flag_clr_i,
  input wire logic ovf_clr_i,
  input wire logic event_clr_i,
  input wire logic event_ie_i,
  input wire logic [RW-1:0] baud_reload_field_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic scl_oe_o,
  output logic sda_o,
  output logic sda_oe_o,
  output logic [7:0] tx_rx_buffer_o,
  output logic buffer_full_flag_o,
  output logic ack_status_o,
  output logic write_collision_flag_o,
  output logic receive_overflow_flag_o,
  output logic receive_enable_bit_o,
  output logic ack_sequence_enable_o,
  output logic serial_event_flag_o,
  output logic irq_o
);
  imbe_pkg::imbe_state_t st_q;
  imbe_pkg::imbe_op_t op_q;
  logic [7:0] shift_register_q;
  logic [3:0] bit_q;
  logic [7:0] win_q;
  logic [2:0] sda_s_q;
  logic tick;
  logic run;
  logic busy;
  logic last_bit;
  logic sda_smp;
  logic sda_f_q;

  // Three-stage pin sampler; only stages two and three are read.
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      sda_s_q <= 3'h7;
    else
      sda_s_q <= {sda_s_q[1:0], sda_i};
  end
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i || sda_s_q[1] == sda_s_q[2])
      sda_f_q <= rst_i || sda_s_q[2];
  end
  assign sda_smp = sda_f_q;

  assign run = (st_q == imbe_pkg::IMBE_LOW) || (st_q == imbe_pkg::IMBE_HIGH);
  assign busy = (st_q != imbe_pkg::IMBE_IDLE) && (st_q != imbe_pkg::IMBE_HOLD);
  assign last_bit = (op_q == imbe_pkg::IMBE_OP_TX) ? (bit_q == 4'h8)
                  : (op_q == imbe_pkg::IMBE_OP_RX) ? (bit_q == 4'h7)
                  : (bit_q == 4'h0);

  imbe_baud_gen #(
    .RW(RW)
  ) u_baud (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .run_i(run),
    .reload_i(baud_reload_field_i),
    .tick_o(tick)
  );

  // Bit sequencer: low half then high half, one baud period each.
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      st_q <= imbe_pkg::IMBE_IDLE;
      op_q <= imbe_pkg::IMBE_OP_TX;
      bit_q <= 4'h0;
      scl_oe_o <= 1'b0;
      sda_oe_o <= 1'b0;
    end
    else
    begin
      unique case (st_q)
        imbe_pkg::IMBE_IDLE, imbe_pkg::IMBE_HOLD:
        begin
          if (buf_wr_i && !busy)
          begin
            st_q <= imbe_pkg::IMBE_LOW;
            op_q <= imbe_pkg::IMBE_OP_TX;
            bit_q <= 4'h0;
            scl_oe_o <= 1'b1;
            sda_oe_o <= !buf_wdata_i[7];
          end
          else if (buf_wr_i && st_q == imbe_pkg::IMBE_HOLD)
          begin
            st_q <= imbe_pkg::IMBE_LOW;
            op_q <= imbe_pkg::IMBE_OP_TX;
            bit_q <= 4'h0;
            sda_oe_o <= !buf_wdata_i[7];
          end
          else if (receive_enable_set_i && !busy)
          begin
            st_q <= imbe_pkg::IMBE_LOW;
            op_q <= imbe_pkg::IMBE_OP_RX;
            bit_q <= 4'h0;
            scl_oe_o <= 1'b1;
            sda_oe_o <= 1'b0;
          end
          else if (ack_sequence_set_i && !busy)
          begin
            st_q <= imbe_pkg::IMBE_LOW;
            op_q <= imbe_pkg::IMBE_OP_ACK;
            bit_q <= 4'h0;
            scl_oe_o <= 1'b1;
            sda_oe_o <= !ack_data_bit_i;
          end
        end
        imbe_pkg::IMBE_LOW:
          if (tick)
          begin
            st_q <= imbe_pkg::IMBE_HIGH;
            scl_oe_o <= 1'b0;
          end
        imbe_pkg::IMBE_HIGH:
          if (tick)
          begin
            scl_oe_o <= 1'b1;
            bit_q <= bit_q + 4'h1;
            if (last_bit)
            begin
              st_q <= imbe_pkg::IMBE_DONE;
              if (op_q != imbe_pkg::IMBE_OP_TX)
                sda_oe_o <= 1'b0;
            end
            else
            begin
              st_q <= imbe_pkg::IMBE_LOW;
              if (op_q == imbe_pkg::IMBE_OP_TX && bit_q < 4'h7)
                sda_oe_o <= !tx_rx_buffer_o[3'd6 - bit_q[2:0]];
              else
                sda_oe_o <= 1'b0;
            end
          end
        imbe_pkg::IMBE_DONE:
          st_q <= (op_q == imbe_pkg::IMBE_OP_TX) ? imbe_pkg::IMBE_HOLD
                                                 : imbe_pkg::IMBE_IDLE;
        default:
          st_q <= imbe_pkg::IMBE_IDLE;
      endcase
    end
  end

  // Open-drain pins only ever drive low.
  always_ff @(posedge core_clk_i)
  begin
    scl_o <= 1'b0;
    sda_o <= 1'b0;
  end

  // Shift register samples SDA at the end of each high half.
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      shift_register_q <= 8'h00;
    else if (st_q == imbe_pkg::IMBE_HIGH && tick)
      shift_register_q <= {shift_register_q[6:0], sda_smp};
  end

  // Acknowledge status from the ninth clock of a transmit.
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      ack_status_o <= 1'b0;
    else if (st_q == imbe_pkg::IMBE_HIGH && tick &&
             op_q == imbe_pkg::IMBE_OP_TX && bit_q == 4'h8)
      ack_status_o <= sda_smp;
  end

  // Collision window after an accepted buffer write.
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      win_q <= 8'h00;
    else if (buf_wr_i && !busy)
      win_q <= 8'(WRITE_COLLISION_FLAG_WIN);
    else if (win_q != 8'h00)
      win_q <= win_q - 8'h01;
  end

  // Buffer contents.
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      tx_rx_buffer_o <= 8'h00;
    else if (st_q == imbe_pkg::IMBE_DONE && op_q == imbe_pkg::IMBE_OP_RX)
      tx_rx_buffer_o <= shift_register_q;
    else if (buf_wr_i && (!busy || st_q == imbe_pkg::IMBE_HOLD))
      tx_rx_buffer_o <= buf_wdata_i;
    else if (buf_wr_i && op_q == imbe_pkg::IMBE_OP_TX && win_q != 8'h00)
      tx_rx_buffer_o <= buf_wdata_i;
  end

  // Buffer-full flag.
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      buffer_full_flag_o <= 1'b0;
    else if (st_q == imbe_pkg::IMBE_DONE && op_q == imbe_pkg::IMBE_OP_RX)
      buffer_full_flag_o <= 1'b1;
    else if (buf_wr_i && (!busy || st_q == imbe_pkg::IMBE_HOLD))
      buffer_full_flag_o <= 1'b1;
    else if (st_q == imbe_pkg::IMBE_HIGH && tick &&
             op_q == imbe_pkg::IMBE_OP_TX && bit_q == 4'h7)
      buffer_full_flag_o <= 1'b0;
    else if (buf_rd_i && op_q != imbe_pkg::IMBE_OP_TX)
      buffer_full_flag_o <= 1'b0;
  end

  // Write collision flag; set wins over software clear.
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      write_collision_flag_o <= 1'b0;
    else if (buf_wr_i && busy && st_q != imbe_pkg::IMBE_HOLD)
      write_collision_flag_o <= 1'b1;
    else if (write_collision_flag_clr_i)
      write_collision_flag_o <= 1'b0;
  end

  // Receive overflow flag.
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      receive_overflow_flag_o <= 1'b0;
    else if (st_q == imbe_pkg::IMBE_DONE && op_q == imbe_pkg::IMBE_OP_RX &&
             buffer_full_flag_o)
      receive_overflow_flag_o <= 1'b1;
    else if (ovf_clr_i)
      receive_overflow_flag_o <= 1'b0;
  end

  // Receive and acknowledge enables clear themselves when done.
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      receive_enable_bit_o <= 1'b0;
      ack_sequence_enable_o <= 1'b0;
    end
    else
    begin
      if (receive_enable_set_i && !busy && !buf_wr_i)
        receive_enable_bit_o <= 1'b1;
      else if (st_q == imbe_pkg::IMBE_DONE)
        receive_enable_bit_o <= 1'b0;
      if (ack_sequence_set_i && !busy && !buf_wr_i && !receive_enable_set_i)
        ack_sequence_enable_o <= 1'b1;
      else if (st_q == imbe_pkg::IMBE_DONE)
        ack_sequence_enable_o <= 1'b0;
    end
  end

  // Serial event flag and interrupt request.
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      serial_event_flag_o <= 1'b0;
      irq_o <= 1'b0;
    end
    else
    begin
      if (st_q == imbe_pkg::IMBE_DONE)
        serial_event_flag_o <= 1'b1;
      else if (event_clr_i)
        serial_event_flag_o <= 1'b0;
      irq_o <= event_ie_i && (serial_event_flag_o ||
               st_q == imbe_pkg::IMBE_DONE);
    end
  end
endmodule : imbe_engine
`default_nettype wire

// >>> include/imbe_params.svh
`ifndef IMBE_PARAMS_SVH
`define IMBE_PARAMS_SVH
`define IMBE_CLK_HZ 20000000
`define IMBE_INSTR_CYCLE_NS 200
`define IMBE_CLK_NS 50
`define IMBE_WRITE_COLLISION_FLAG_WIN_CYC ((2 * `IMBE_INSTR_CYCLE_NS) / `IMBE_CLK_NS)
`define IMBE_RELOAD_W 7
`define IMBE_RESET_RELOAD 7'h09
`define IMBE_BITS 8
`endif

// >>> include/imbe_pkg.sv
package imbe_pkg;
  typedef enum logic [4:0] {
    IMBE_IDLE = 5'b0_0001,
    IMBE_LOW = 5'b0_0010,
    IMBE_HIGH = 5'b0_0100,
    IMBE_HOLD = 5'b0_1000,
    IMBE_DONE = 5'b1_0000
  } imbe_state_t;
  typedef enum logic [1:0] {
    IMBE_OP_TX = 2'h0,
    IMBE_OP_RX = 2'h1,
    IMBE_OP_ACK = 2'h2
  } imbe_op_t;
endpackage : imbe_pkg

// >>> design/imbe_baud_gen.sv
`timescale 1ns/1ns
`default_nettype none
`include "imbe_params.svh"
module imbe_baud_gen #(
  parameter int RW = `IMBE_RELOAD_W
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic [RW-1:0] reload_i,
  output logic tick_o
);
  logic [RW-1:0] cnt_q;
  // Counts down and reloads from the reload field on each rollover.
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i || !run_i)
    begin
      cnt_q <= reload_i;
      tick_o <= 1'b0;
    end
    else if (cnt_q == '0)
    begin
      cnt_q <= reload_i;
      tick_o <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q - 1'b1;
      tick_o <= 1'b0;
    end
  end
endmodule : imbe_baud_gen
`default_nettype wire

// >>> tb/imbe_engine_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module imbe_engine_monitor (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic buf_wr_i,
  input wire logic buf_rd_i,
  input wire logic write_collision_flag_clr_i,
  input wire logic event_ie_i,
  input wire logic scl_oe_o,
  input wire logic sda_oe_o,
  input wire logic buffer_full_flag_o,
  input wire logic write_collision_flag_o,
  input wire logic receive_enable_bit_o,
  input wire logic serial_event_flag_o,
  input wire logic irq_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);
  tx_start_a: assert property (
    (!scl_oe_o && !sda_oe_o) [*8] ##0 buf_wr_i
    |=> buffer_full_flag_o && scl_oe_o) else $error("tx start");
  write_collision_flag_hold_a: assert property (
    write_collision_flag_o && !write_collision_flag_clr_i |=> write_collision_flag_o)
    else $error("write_collision_flag lost");
  write_collision_flag_rx_a: assert property (
    buf_wr_i && receive_enable_bit_o |=> write_collision_flag_o)
    else $error("write_collision_flag rx");
  rx_done_a: assert property (
    $fell(receive_enable_bit_o) |-> ##[0:3]
    (serial_event_flag_o && buffer_full_flag_o && scl_oe_o))
    else $error("rx done");
  rd_clear_a: assert property (
    buf_rd_i && buffer_full_flag_o && serial_event_flag_o
    && !receive_enable_bit_o && !buf_wr_i |=> !buffer_full_flag_o)
    else $error("rd clear");
  ev_hold_a: assert property (
    $rose(serial_event_flag_o) |-> scl_oe_o ##1 scl_oe_o)
    else $error("scl free");
  rx_free_a: assert property (
    receive_enable_bit_o [*3] |-> !sda_oe_o) else $error("sda driven");
  irq_set_a: assert property (
    $rose(serial_event_flag_o) && event_ie_i |-> ##[0:1] irq_o)
    else $error("no irq");
endmodule : imbe_engine_monitor
`default_nettype wire

// >>> tb/imbe_slave_model.sv
`timescale 1ns/1ns
`default_nettype none
module imbe_slave_model (
  input wire logic core_clk_i,
  input wire logic clr_i,
  input wire logic rx_mode_i,
  input wire logic ack_en_i,
  input wire logic [7:0] rx_byte_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_oe_o,
  output logic [7:0] got_o
);
  logic scl_q;
  logic [3:0] rise_q;
  // Data changes only after a falling SCL edge or when clr_i loads the first bit.
  always_ff @(posedge core_clk_i)
  begin
    scl_q <= scl_i;
    if (clr_i)
    begin
      rise_q <= 4'h0;
      sda_oe_o <= rx_mode_i && !rx_byte_i[7];
    end
    else if (!scl_q && scl_i)
    begin
      rise_q <= rise_q + 4'h1;
      if (rise_q < 4'h8)
      begin
        got_o <= {got_o[6:0], sda_i};
      end
    end
    else if (scl_q && !scl_i)
    begin
      sda_oe_o <= rx_mode_i ? (rise_q < 4'h8 &&
        !rx_byte_i[3'h7 - rise_q[2:0]]) : (rise_q == 4'h8 && ack_en_i);
    end
  end
endmodule : imbe_slave_model
`default_nettype wire

// >>> tb/imbe_engine_tb.sv
`timescale 1ns/1ns
`default_nettype none
module imbe_engine_tb;
  `define CHK(a, b) \
    tests_run++; \
    if ((a) !== (b)) \
    begin \
      fail_count++; \
      $display("[ERR] %0t got %h want %h", $time, a, b); \
    end
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] pl = 8'h00;
  logic [7:0] buf_wdata_i = 8'h00;
  logic rx_mode = 1'b0;
  logic ack_en = 1'b0;
  logic seen;
  logic [7:0] rx_byte = 8'h00;
  logic [7:0] got;
  logic [7:0] tx_rx_buffer_o;
  logic s_oe, scl_oe_o, sda_oe_o, buffer_full_flag_o, ack_status_o;
  logic write_collision_flag_o, receive_overflow_flag_o, receive_enable_bit_o;
  logic ack_sequence_enable_o, serial_event_flag_o, irq_o;
  int fail_count = 0, tests_run = 0, cyc = 0, n;
  logic [10:0] rows [5] = '{11'h2a5, 11'h13c, 11'h280, 11'h45a, 11'h401};
  wire scl = !scl_oe_o;
  wire sda = !(sda_oe_o || s_oe);
  imbe_engine imbe_engine_inst (
    .core_clk_i, .rst_i, .buf_wr_i(pl[0]), .buf_wdata_i, .buf_rd_i(pl[1]),
    .receive_enable_set_i(pl[2]), .ack_sequence_set_i(pl[3]),
    .ack_data_bit_i(1'b0), .write_collision_flag_clr_i(pl[4]), .ovf_clr_i(pl[6]),
    .event_clr_i(pl[5]), .event_ie_i(1'b1), .baud_reload_field_i(7'h02),
    .scl_i(scl), .sda_i(sda), .scl_o(), .scl_oe_o, .sda_o(), .sda_oe_o,
    .tx_rx_buffer_o, .buffer_full_flag_o, .ack_status_o,
    .write_collision_flag_o, .receive_overflow_flag_o, .receive_enable_bit_o,
    .ack_sequence_enable_o, .serial_event_flag_o, .irq_o);
  imbe_slave_model imbe_slave_model_inst (.core_clk_i,
    .clr_i(pl[7] || rst_i), .rx_mode_i(rx_mode), .ack_en_i(ack_en),
    .rx_byte_i(rx_byte), .scl_i(scl), .sda_i(sda), .sda_oe_o(s_oe),
    .got_o(got));
  always #25 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      end_of_test();
    end
  end
  task automatic end_of_test;
    if (fail_count == 0 && tests_run > 0)
    begin
      $display("ALL CHECKS OK");
    end
    else
    begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test
  task automatic pulse(input logic [7:0] m, input logic [7:0] d);
    @(posedge core_clk_i);
    pl <= m;
    buf_wdata_i <= d;
    @(posedge core_clk_i);
    pl <= 8'h00;
    @(negedge core_clk_i);
  endtask : pulse
  task automatic wait_ev;
    n = 0;
    while (serial_event_flag_o !== 1'b1 && n < 2000)
    begin
      @(negedge core_clk_i);
      n++;
    end
  endtask : wait_ev
  initial
  begin
    repeat (12) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(negedge core_clk_i);
    `CHK({buffer_full_flag_o, scl_oe_o, serial_event_flag_o}, 3'h0)
    repeat (10) @(posedge core_clk_i);
    foreach (rows[i])
    begin
      rx_mode <= rows[i][10];
      ack_en <= rows[i][9];
      rx_byte <= rows[i][7:0];
      pulse(rows[i][10] ? 8'h84 : 8'h81, rows[i][7:0]);
      wait_ev();
      if (rows[i][10])
      begin
        `CHK(tx_rx_buffer_o, rows[i][7:0])
        `CHK(buffer_full_flag_o, 1'b1)
        pulse(8'h02, 8'h00);
        `CHK(buffer_full_flag_o, 1'b0)
      end
      else
      begin
        `CHK(got, rows[i][7:0])
        `CHK(ack_status_o, rows[i][8])
        `CHK(buffer_full_flag_o, 1'b0)
      end
      pulse(8'h20, 8'h00);
    end
    rx_mode <= 1'b0;
    ack_en <= 1'b1;
    pulse(8'h81, 8'h12);
    pulse(8'h01, 8'h34);
    `CHK(write_collision_flag_o, 1'b1)
    `CHK(tx_rx_buffer_o, 8'h34)
    repeat (10) @(posedge core_clk_i);
    pulse(8'h04, 8'h00);
    `CHK(receive_enable_bit_o, 1'b0)
    pulse(8'h01, 8'h56);
    `CHK(tx_rx_buffer_o, 8'h34)
    wait_ev();
    pulse(8'h30, 8'h00);
    `CHK(write_collision_flag_o, 1'b0)
    rx_mode <= 1'b1;
    rx_byte <= 8'hc3;
    pulse(8'h84, 8'h00);
    repeat (10) @(posedge core_clk_i);
    pulse(8'h01, 8'h77);
    `CHK(tx_rx_buffer_o, 8'h34)
    wait_ev();
    pulse(8'h30, 8'h00);
    pulse(8'h84, 8'h00);
    wait_ev();
    `CHK(receive_overflow_flag_o, 1'b1)
    pulse(8'h62, 8'h00);
    `CHK({receive_overflow_flag_o, buffer_full_flag_o}, 2'b00)
    pulse(8'h08, 8'h00);
    seen = sda_oe_o;
    n = 0;
    while (ack_sequence_enable_o === 1'b1 && n < 300)
    begin
      @(negedge core_clk_i);
      seen |= sda_oe_o;
      n++;
    end
    `CHK(seen, 1'b1)
    `CHK(ack_sequence_enable_o, 1'b0)
    pulse(8'h81, 8'hf0);
    @(posedge core_clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(negedge core_clk_i);
    `CHK({buffer_full_flag_o, scl_oe_o, serial_event_flag_o}, 3'h0)
    end_of_test();
  end
endmodule : imbe_engine_tb
bind imbe_engine imbe_engine_monitor monitor_inst (.core_clk_i, .rst_i,
  .buf_wr_i, .buf_rd_i, .write_collision_flag_clr_i, .event_ie_i, .scl_oe_o, .sda_oe_o,
  .buffer_full_flag_o, .write_collision_flag_o, .receive_enable_bit_o,
  .serial_event_flag_o, .irq_o);
`default_nettype wire
